/* src/speep_pkg.sv */
// Package with opcodes, status layout and timing constants of the serial EEPROM front end
package speep_pkg;
   // Opcode low nibble after masking bit 3; upper nibble must be zero
   localparam logic [7:0] SPEEP_OP_MASK = 8'hF7;
   localparam logic [7:0] SPEEP_OP_SET_WRITE_LATCH = 8'h06;
   localparam logic [7:0] SPEEP_OP_CLEAR_WRITE_LATCH = 8'h04;
   localparam logic [7:0] SPEEP_OP_STATUS_READ = 8'h05;
   localparam logic [7:0] SPEEP_OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] SPEEP_OP_ARRAY_READ = 8'h03;
   localparam logic [7:0] SPEEP_OP_ARRAY_WRITE = 8'h02;
   // Status register bit positions
   localparam int SPEEP_SR_BUSY = 0;
   localparam int SPEEP_SR_WEN = 1;
   localparam int SPEEP_SR_BP_LO = 2;
   localparam int SPEEP_SR_BP_HI = 3;
   localparam int SPEEP_SR_PEN = 7;
   localparam logic [7:0] SPEEP_SR_BUSY_VALUE = 8'hFF;
   // Nonvolatile bits come up cleared in this model
   localparam logic [1:0] SPEEP_BP_RESET = 2'h0;
   localparam logic SPEEP_PEN_RESET = 1'b0;
   // Protected region lower bounds for the 10-bit array
   localparam logic [9:0] SPEEP_BOUND_QUARTER = 10'h300;
   localparam logic [9:0] SPEEP_BOUND_HALF = 10'h200;
   localparam logic [9:0] SPEEP_BOUND_ALL = 10'h000;
   // Self-timed write cycle
   localparam int SPEEP_CLK_HZ = 100_000_000;
   localparam int SPEEP_TWC_MS = 5;
   localparam int SPEEP_TWC_CYCLES = SPEEP_CLK_HZ / 1000 * SPEEP_TWC_MS;
   localparam int SPEEP_CNT_W = 20;
   typedef enum logic [2:0] {
      SPEEP_ST_IDLE,
      SPEEP_ST_OPCODE,
      SPEEP_ST_STATUS_OUT,
      SPEEP_ST_STATUS_IN,
      SPEEP_ST_DONE,
      SPEEP_ST_REJECT
   } speep_state_t;
endpackage

/* src/speep_core.sv */
// Serial slave front end: opcode decode, write latch, status register and protection
`timescale 1ns/100ps
`default_nettype none

module speep_core #(
   parameter int P_TWC_CYCLES = speep_pkg::SPEEP_TWC_CYCLES
) (
   // System
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   // Serial link pins
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic i_si,
   input wire logic i_hold_n,
   input wire logic i_wp_n,
   output logic o_so,
   output logic o_so_oe,
   // Array side protection check
   input wire logic [9:0] i_array_addr,
   output logic o_array_addr_writable,
   // Status view
   output logic [7:0] o_status
);
   import speep_pkg::*;

   // Synchronised pins and their edges
   logic [4:0] sync_a;
   logic [4:0] sync_b;
   logic sck_d;
   logic cs_d;
   logic wp_d;
   logic hold_act;
   logic sck_rise;
   logic sck_fall;
   logic cs_fall;
   logic cs_rise;
   logic wp_fall;
   logic sel;

   // Serial sequencer
   speep_state_t state;
   logic [7:0] shreg;
   logic [7:0] rx_byte;
   logic [2:0] bitcnt;
   logic [7:0] instr;
   logic opcode_done;

   // Status register and the timed write cycle
   logic wen;
   logic [1:0] bp;
   logic pen;
   logic busy;
   logic commit;
   logic [SPEEP_CNT_W-1:0] twc_cnt;
   logic sr_pending;
   logic sr_capture;
   logic [7:0] sr_new;
   logic start_write;
   logic [7:0] status_now;

   // Serial output
   logic [7:0] out_byte;

   function automatic logic op_is(input logic [7:0] op, input logic [7:0] code);
      op_is = ((op & SPEEP_OP_MASK) == code);
   endfunction

   function automatic logic op_known(input logic [7:0] op);
      op_known = op_is(op, SPEEP_OP_SET_WRITE_LATCH) | op_is(op, SPEEP_OP_CLEAR_WRITE_LATCH) |
                 op_is(op, SPEEP_OP_STATUS_READ) | op_is(op, SPEEP_OP_STATUS_WRITE) |
                 op_is(op, SPEEP_OP_ARRAY_READ) | op_is(op, SPEEP_OP_ARRAY_WRITE);
   endfunction

   // Region guarded by the block-protect pair
   function automatic logic addr_protected(input logic [1:0] level, input logic [9:0] addr);
      case (level)
         2'h1: addr_protected = (addr >= SPEEP_BOUND_QUARTER);
         2'h2: addr_protected = (addr >= SPEEP_BOUND_HALF);
         2'h3: addr_protected = (addr >= SPEEP_BOUND_ALL);
         default: addr_protected = 1'b0;
      endcase
   endfunction

   // Two-stage synchronisers for sck, cs_n, si, hold_n, wp_n
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sync_a <= 5'h1E;
         sync_b <= 5'h1E;
      end else begin
         sync_a <= {i_wp_n, i_hold_n, i_si, i_cs_n, i_sck};
         sync_b <= sync_a;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sck_d <= 1'b0;
         cs_d <= 1'b1;
         wp_d <= 1'b1;
      end else begin
         sck_d <= sync_b[0];
         cs_d <= sync_b[1];
         wp_d <= sync_b[4];
      end
   end

   // Pause enters and leaves while sck is low; chip deselect ends it at any sck level
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         hold_act <= 1'b0;
      end else if (sync_b[1]) begin
         hold_act <= 1'b0;
      end else if (!sync_b[0]) begin
         hold_act <= !sync_b[3];
      end
   end

   // sck is only sampled, edges found in the system clock
   assign sck_rise = sync_b[0] & !sck_d;
   assign sck_fall = !sync_b[0] & sck_d;
   assign cs_fall = !sync_b[1] & cs_d;
   assign cs_rise = sync_b[1] & !cs_d;
   assign wp_fall = !sync_b[4] & wp_d;
   // Byte as it stands once the current input bit is shifted in
   assign rx_byte = {shreg[6:0], sync_b[2]};
   assign opcode_done = sel && sck_rise && !cs_fall && state == SPEEP_ST_OPCODE && bitcnt == 3'h7;
   assign sr_capture = sel && sck_rise && !cs_fall && state == SPEEP_ST_STATUS_IN && bitcnt == 3'h7;
   assign commit = busy && (twc_cnt == '0);
   assign sel = !sync_b[1] & !hold_act;

   assign status_now = busy ? SPEEP_SR_BUSY_VALUE :
                       {pen, 3'h0, bp, wen, 1'b0};

   // Serial sequencer
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state <= SPEEP_ST_IDLE;
         shreg <= 8'h00;
         bitcnt <= 3'h0;
      end else if (sync_b[1]) begin
         state <= SPEEP_ST_IDLE;
         bitcnt <= 3'h0;
      end else if (cs_fall) begin
         state <= SPEEP_ST_OPCODE;
         bitcnt <= 3'h0;
      end else if (sel && sck_rise) begin
         // A rejected opcode takes no further bits in
         if (state != SPEEP_ST_REJECT) begin
            shreg <= rx_byte;
         end
         bitcnt <= bitcnt + 3'h1;
         case (state)
            SPEEP_ST_OPCODE: begin
               if (bitcnt == 3'h7) begin
                  if (!op_known(rx_byte)) begin
                     state <= SPEEP_ST_REJECT;
                  end else if (busy && !op_is(rx_byte, SPEEP_OP_STATUS_READ)) begin
                     state <= SPEEP_ST_REJECT;
                  end else if (op_is(rx_byte, SPEEP_OP_STATUS_READ)) begin
                     state <= SPEEP_ST_STATUS_OUT;
                  end else if (op_is(rx_byte, SPEEP_OP_STATUS_WRITE)) begin
                     state <= SPEEP_ST_STATUS_IN;
                  end else begin
                     state <= SPEEP_ST_DONE;
                  end
               end
            end
            SPEEP_ST_STATUS_IN: begin
               if (bitcnt == 3'h7) begin
                  state <= SPEEP_ST_DONE;
               end
            end
            SPEEP_ST_STATUS_OUT: begin
               state <= SPEEP_ST_STATUS_OUT;
            end
            SPEEP_ST_DONE, SPEEP_ST_REJECT, SPEEP_ST_IDLE: begin
               state <= state;
            end
            default: begin
               state <= SPEEP_ST_IDLE;
            end
         endcase
      end
   end

   // Instruction register, loaded when the eighth opcode bit arrives
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         instr <= 8'h00;
      end else if (opcode_done) begin
         instr <= rx_byte;
      end
   end

   // Status write request; a falling protect pin while selected drops it
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sr_pending <= 1'b0;
      end else if (sync_b[1]) begin
         sr_pending <= 1'b0;
      end else if (cs_fall) begin
         sr_pending <= 1'b0;
      end else if (wp_fall) begin
         sr_pending <= 1'b0;
      end else if (sr_capture) begin
         sr_pending <= wen && !(pen && !sync_b[4]);
      end
   end

   // New status byte, kept until the timed cycle commits it
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sr_new <= 8'h00;
      end else if (sr_capture && !busy) begin
         sr_new <= rx_byte;
      end
   end

   // Start the timed cycle on chip select release
   assign start_write = cs_rise && sr_pending && !busy;

   // Busy flag of the self-timed cycle
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         busy <= 1'b0;
      end else if (start_write) begin
         busy <= 1'b1;
      end else if (commit) begin
         busy <= 1'b0;
      end
   end

   // Down counter of the self-timed cycle
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         twc_cnt <= '0;
      end else if (start_write) begin
         twc_cnt <= SPEEP_CNT_W'(P_TWC_CYCLES - 1);
      end else if (busy && twc_cnt != '0) begin
         twc_cnt <= twc_cnt - 1'b1;
      end
   end

   // Nonvolatile protection bits, committed at end of the cycle
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         bp <= SPEEP_BP_RESET;
         pen <= SPEEP_PEN_RESET;
      end else if (commit) begin
         bp <= sr_new[SPEEP_SR_BP_HI:SPEEP_SR_BP_LO];
         if (!(pen && !wp_d && !sr_new[SPEEP_SR_PEN])) begin
            pen <= sr_new[SPEEP_SR_PEN];
         end
      end
   end

   // Write latch
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wen <= 1'b0;
      end else if (commit) begin
         wen <= 1'b0;
      end else if (cs_rise && state == SPEEP_ST_DONE) begin
         if (op_is(instr, SPEEP_OP_SET_WRITE_LATCH)) begin
            wen <= 1'b1;
         end else if (op_is(instr, SPEEP_OP_CLEAR_WRITE_LATCH)) begin
            wen <= 1'b0;
         end
      end
   end

   // Output enable: driven only while selected, not paused, in a status read
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_so_oe <= 1'b0;
      end else begin
         o_so_oe <= sel && state == SPEEP_ST_STATUS_OUT;
      end
   end

   // Output shifter: load on opcode completion, shift on falling sck
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         out_byte <= 8'h00;
         o_so <= 1'b0;
      end else if (state != SPEEP_ST_STATUS_OUT) begin
         out_byte <= status_now;
      end else if (sel && sck_fall) begin
         o_so <= out_byte[7];
         out_byte <= {out_byte[6:0], out_byte[7]};
      end
   end

   // Status view
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_status <= 8'h00;
      end else begin
         o_status <= status_now;
      end
   end

   // Block protection check; unprotected regions stay writable under the pin
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_array_addr_writable <= 1'b0;
      end else begin
         o_array_addr_writable <= wen && !addr_protected(bp, i_array_addr);
      end
   end
endmodule

`default_nettype wire

/* tb/speep_core_assertions.sv */
// Port checker of the serial EEPROM front end
`timescale 1ns/100ps
`default_nettype none
module speep_core_assertions
   import speep_pkg::*;
#(
   parameter int P_TWC_CYCLES = SPEEP_TWC_CYCLES
) (
   // System
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   // Serial link
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic i_si,
   input wire logic i_hold_n,
   input wire logic i_wp_n,
   input wire logic o_so,
   input wire logic o_so_oe,
   // Array check and status
   input wire logic [9:0] i_array_addr,
   input wire logic o_array_addr_writable,
   input wire logic [7:0] o_status
);
   int busy_cnt;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_arst_n);
   // Length of the self-timed cycle as seen on the status view
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         busy_cnt <= 0;
      end else begin
         busy_cnt <= o_status[SPEEP_SR_BUSY] ? busy_cnt + 1 : 0;
      end
   end
   chk_oe_deselect: assert property (i_cs_n [*5] |-> !o_so_oe)
      else $error("serial out driven while deselected");
   chk_so_after_fall: assert property (o_so_oe && $past(o_so_oe) && $changed(o_so) |-> !i_sck)
      else $error("serial out changed while serial clock high");
   chk_busy_ones: assert property (o_status[SPEEP_SR_BUSY] |-> o_status == SPEEP_SR_BUSY_VALUE)
      else $error("busy status not all ones");
   chk_idle_zero_bits: assert property (!o_status[SPEEP_SR_BUSY] |-> o_status[6:4] == 3'h0)
      else $error("status bits 6 to 4 not zero when idle");
   chk_latch_end_clear: assert property ($fell(o_status[SPEEP_SR_BUSY]) |-> !o_status[SPEEP_SR_WEN])
      else $error("write latch still set after write cycle");
   chk_power_up_clear: assert property ($rose(i_arst_n) |-> o_status == 8'h00)
      else $error("status not clear after reset");
   chk_no_latch_write: assert property ((!o_status[SPEEP_SR_WEN]) [*3] |-> !o_array_addr_writable)
      else $error("array writable without write latch");
   chk_top_quarter: assert property ((!o_status[0] && o_status[3:2] != 2'h0 && i_array_addr >= 10'h300) [*3]
      |-> !o_array_addr_writable)
      else $error("protected upper quarter writable");
   chk_whole_array: assert property ((!o_status[0] && o_status[3:2] == 2'h3) [*3] |-> !o_array_addr_writable)
      else $error("fully protected array writable");
   chk_busy_bound: assert property (busy_cnt <= P_TWC_CYCLES + 8)
      else $error("write cycle runs too long");
   cov_write_cycle: cover property ($fell(o_status[SPEEP_SR_BUSY]));
   cov_so_driven: cover property (o_so_oe);
   cov_addr_open: cover property (o_array_addr_writable);
   cov_pause: cover property (!i_cs_n && !i_hold_n);
endmodule

bind speep_core speep_core_assertions #(.P_TWC_CYCLES(P_TWC_CYCLES)) u_chk (.*);
`default_nettype wire

/* tb/speep_host_model.sv */
// Host controller model driving the serial link pins in mode 0
`timescale 1ns/100ps
`default_nettype none
module speep_host_model (
   // Bench clock, used only to start frames off its edge
   input wire logic i_clk,
   // Link pins toward the device
   output logic o_sck,
   output logic o_cs_n,
   output logic o_si,
   output logic o_hold_n,
   // Serial answer from the device
   input wire logic i_so,
   input wire logic i_so_oe
);
   logic oe_seen;
   initial begin
      o_sck = 1'b0;
      o_cs_n = 1'b1;
      o_si = 1'b0;
      o_hold_n = 1'b1;
      oe_seen = 1'b0;
   end
   always @(posedge i_so_oe) oe_seen = 1'b1;
   // Sends n bits of tx from the top, pausing once after bit hold_at if nonzero;
   // rx keeps the last eight bits seen, x where undriven
   task automatic frame(input logic [15:0] tx, input int n, input int hold_at, output logic [7:0] rx);
      @(posedge i_clk);
      #1 o_cs_n = 1'b0;
      #160;
      for (int i = 15; i >= 16 - n; i--) begin
         o_si = tx[i];
         #80 o_sck = 1'b1;
         rx = {rx[6:0], i_so_oe ? i_so : 1'bx};
         #80 o_sck = 1'b0;
         if (16 - i == hold_at) begin
            #40 o_hold_n = 1'b0;
            #40 o_sck = 1'b1;
            o_si = ~o_si;
            #80 o_sck = 1'b0;
            #40 o_hold_n = 1'b1;
            #120;
         end
      end
      #160 o_cs_n = 1'b1;
      o_si = ~o_si;
      #320;
   endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Testbench of the serial EEPROM front end
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
   $display("Error %0t got %h exp %h", $time, a, b); end end
module tb_top;
   import speep_pkg::*;
   localparam int TWC = 2000;
   logic i_clk_sys, i_arst_n, i_sck, i_cs_n, i_si, i_hold_n, i_wp_n, o_so, o_so_oe, o_array_addr_writable;
   logic [9:0] i_array_addr;
   logic [7:0] o_status, rx;
   int miscompares, checks_done, cycles;
   speep_core #(.P_TWC_CYCLES(TWC)) dut (.i_clk_sys, .i_arst_n, .i_sck, .i_cs_n, .i_si, .i_hold_n, .i_wp_n,
      .o_so, .o_so_oe, .i_array_addr, .o_array_addr_writable, .o_status);
   speep_host_model host (.i_clk(i_clk_sys), .o_sck(i_sck), .o_cs_n(i_cs_n), .o_si(i_si), .o_hold_n(i_hold_n),
      .i_so(o_so), .i_so_oe(o_so_oe));
   initial begin
      i_clk_sys = 1'b0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys) begin
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic op(input logic [7:0] code);
      host.frame({code, 8'h00}, 8, 0, rx);
   endtask
   task automatic status_write_cmd(input logic [7:0] val);
      host.frame({SPEEP_OP_STATUS_WRITE, val}, 16, 0, rx);
   endtask
   task automatic status_read_cmd(input logic [7:0] exp);
      host.frame({SPEEP_OP_STATUS_READ, 8'h00}, 16, 0, rx);
      `CHK(rx, exp)
   endtask
   task automatic wait_ready();
      for (int k = 0; k < 3000 && o_status[SPEEP_SR_BUSY] !== 1'b0; k++) @(posedge i_clk_sys);
   endtask
   task automatic chk_addr(input logic [9:0] a, input logic exp);
      @(posedge i_clk_sys) #1 i_array_addr = a;
      repeat (3) @(posedge i_clk_sys);
      #1 `CHK(o_array_addr_writable, exp)
   endtask
   initial begin
      i_arst_n = 1'b0;
      i_wp_n = 1'b1;
      i_array_addr = 10'h000;
      repeat (12) @(posedge i_clk_sys);
      #1 i_arst_n = 1'b1;
      repeat (5) @(posedge i_clk_sys);
      status_read_cmd(8'h00);
      op(8'h0E);
      host.frame(16'h0D00, 16, 0, rx);
      `CHK(rx, 8'h02)
      host.frame({SPEEP_OP_STATUS_READ, 8'h00}, 16, 4, rx);
      `CHK(rx, 8'h02)
      host.frame({SPEEP_OP_STATUS_READ, 8'h00}, 16, 12, rx);
      `CHK(rx, 8'h02)
      i_wp_n = 1'b0;
      op(SPEEP_OP_CLEAR_WRITE_LATCH);
      status_read_cmd(8'h00);
      $display("test latch done");
      host.oe_seen = 1'b0;
      host.frame(16'hA5FF, 16, 0, rx);
      `CHK(host.oe_seen, 1'b0)
      $display("test unknown opcode done");
      i_wp_n = 1'b1;
      op(SPEEP_OP_SET_WRITE_LATCH);
      status_write_cmd(8'hFC);
      `CHK(o_status, SPEEP_SR_BUSY_VALUE)
      status_read_cmd(8'hFF);
      op(SPEEP_OP_SET_WRITE_LATCH);
      wait_ready();
      status_read_cmd(8'h8C);
      $display("test status write done");
      op(SPEEP_OP_SET_WRITE_LATCH);
      chk_addr(10'h000, 1'b0);
      i_wp_n = 1'b0;
      status_write_cmd(8'h04);
      wait_ready();
      status_read_cmd(8'h8E);
      i_wp_n = 1'b1;
      status_write_cmd(8'h84);
      wait_ready();
      status_read_cmd(8'h84);
      op(SPEEP_OP_SET_WRITE_LATCH);
      i_wp_n = 1'b0;
      chk_addr(10'h2FF, 1'b1);
      chk_addr(10'h300, 1'b0);
      $display("test protection done");
      i_wp_n = 1'b1;
      fork
         status_write_cmd(8'h00);
         #2760 i_wp_n = 1'b0;
      join
      wait_ready();
      `CHK(o_status[7:2], 6'h21)
      $display("test protect pin abort done");
      wrap_up();
   end
endmodule
`default_nettype wire
